// ### rtl/dlct_timers.sv
// Top of the dual counter/timer: control register, prescaler, pin sampling, two counters.
// Assumes a byte-wide SFR port from the CPU core with bit-access strobes and vector acks.
//
// Summary of operation
// - 13-bit mode uses high byte plus low five bits; low bits 7..5 ignored.
// - 13-bit wrap from all ones sets overflow flag and requests interrupt.
// - Edge-count select set counts falling edges on the timer pin; under split, timer 1 ignores it and counts clocks.
// - Otherwise count system clock or shared prescaler, chosen by clock select.
// - Count only when run set and gate off or external input active; under split, timer 1 ignores both run and gate.
// - Setting run never clears or preloads counts.
// - Timer 1 matches timer 0 modes 0-2, stops in mode 3, gated by second external input.
// - 16-bit mode uses all sixteen bits, overflow on wrap from all ones.
// - Auto-reload counts low byte, reloads it from high byte on wrap.
// - Split mode low byte is timer 0's own independent 8-bit counter.
// - Split mode high byte counts clocks only, run by timer 1 run, sets flag 1.
// - Under split, timer 1 runs in modes 0-2, stops in 3, never flags.
// - Overflow flags set by hardware, software clearable, cleared on vectoring.
// - Control bits 7..0: TF1,TR1,TF0,TR0,IE1,IT1,IE0,IT0 layout; reset zero.
// - Type bit 0 selects level, 1 selects edge detection, sense by polarity.
// - External flags set by hardware, clearable, auto-cleared on vector if edge.
// - Control register at fixed address, supports bit and byte access.
// - Mode field codes 13-bit, 16-bit, auto-reload, split or inactive.
// - Prescaler divides by 12, 4, 48, or external clock by 8 synchronized.
`timescale 1ns/1ps
`include "dlct_defs.svh"
module dlct_timers
	import dlct_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [7:0] sfrAddr,
	input wire logic [7:0] sfrWdata,
	input wire logic sfrWrite,
	input wire logic sfrBitWrite,
	input wire logic [2:0] sfrBitSel,
	output logic [7:0] ctrlRdata,
	input wire logic loadLow0,
	input wire logic loadHigh0,
	input wire logic loadLow1,
	input wire logic loadHigh1,
	input wire logic [7:0] loadData,
	output dlct_count_t count0,
	output dlct_count_t count1,
	input wire dlct_cfg_t cfg0,
	input wire dlct_cfg_t cfg1,
	input wire logic [1:0] shared_prescale_code,
	input wire logic ext_irq0_polarity,
	input wire logic ext_irq1_polarity,
	input wire logic ext_irq0_input,
	input wire logic ext_irq1_input,
	input wire logic counter0_edge_pin,
	input wire logic counter1_edge_pin,
	input wire logic extClockPin,
	input wire logic irqEnable0,
	input wire logic irqEnable1,
	input wire logic vectorAck0,
	input wire logic vectorAck1,
	input wire logic vectorAckExt0,
	input wire logic vectorAckExt1,
	output logic irqReq0,
	output logic irqReq1,
	output logic extIrqReq0,
	output logic extIrqReq1,
	output logic counter1_overflow_pulse
);
	logic [7:0] timer_run_and_flag_control;
	logic [7:0] next_ctrl;
	logic [4:0] syncA;
	logic [4:0] syncB;
	logic [4:0] syncPrev;
	logic [5:0] preCount;
	logic [2:0] extDivCount;
	logic preTick;
	logic extTick;
	logic lowWrap0;
	logic fullWrap0;
	logic highWrap0;
	logic lowWrap1;
	logic fullWrap1;

	// Two-stage synchronisers: irq0, irq1, pin0, pin1, external clock
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			syncA <= '0;
			syncB <= '0;
			syncPrev <= '0;
		end else begin
			syncA <= {extClockPin, counter1_edge_pin, counter0_edge_pin, ext_irq1_input, ext_irq0_input};
			syncB <= syncA;
			syncPrev <= syncB;
		end
	end

	// Polarity-adjusted external interrupt levels and falling edges on count pins
	wire logic irqActive0 = (syncB[0] == ext_irq0_polarity);
	wire logic irqActive1 = (syncB[1] == ext_irq1_polarity);
	wire logic irqRise0 = irqActive0 & ~(syncPrev[0] == ext_irq0_polarity);
	wire logic irqRise1 = irqActive1 & ~(syncPrev[1] == ext_irq1_polarity);
	wire logic pinFall0 = syncPrev[2] & ~syncB[2];
	wire logic pinFall1 = syncPrev[3] & ~syncB[3];
	wire logic extClkRise = syncB[4] & ~syncPrev[4];

	// Shared prescaler terminal counts
	wire logic [5:0] preLast = (shared_prescale_code == `DLCT_PRE_DIV12) ? `DLCT_DIV12_LAST :
		(shared_prescale_code == `DLCT_PRE_DIV4) ? `DLCT_DIV4_LAST : `DLCT_DIV48_LAST;
	wire logic useExt = (shared_prescale_code == `DLCT_PRE_EXT8);
	wire logic preOut = useExt ? extTick : preTick;

	// Prescaler counters; the external path divides synchronised rising edges
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			preCount <= '0;
			preTick <= 1'b0;
			extDivCount <= '0;
			extTick <= 1'b0;
		end else begin
			preTick <= (preCount >= preLast);
			preCount <= (preCount >= preLast) ? 6'h00 : preCount + 6'h01;
			extTick <= extClkRise && (extDivCount == 3'(`DLCT_EXT8_LAST));
			if (extClkRise)
				extDivCount <= extDivCount + 3'h1;
		end
	end

	wire logic run0 = timer_run_and_flag_control[`DLCT_BIT_TR0];
	wire logic run1 = timer_run_and_flag_control[`DLCT_BIT_TR1];
	wire logic split = (cfg0.modeField == `DLCT_MODE_SPLIT);
	wire logic mode1Off = (cfg1.modeField == `DLCT_MODE_SPLIT);
	// Gated enables
	wire logic enable0 = run0 & (~cfg0.gateEnable | irqActive0);
	wire logic enable1Norm = run1 & (~cfg1.gateEnable | irqActive1);
	wire logic enable1 = split ? ~mode1Off : (enable1Norm & ~mode1Off);
	// Clock source selection
	wire logic clkSrc0 = cfg0.sysclkSelect ? 1'b1 : preOut;
	wire logic clkSrc1 = cfg1.sysclkSelect ? 1'b1 : preOut;
	wire logic src0 = cfg0.edgeCountSelect ? pinFall0 : clkSrc0;
	wire logic src1 = (cfg1.edgeCountSelect && !split) ? pinFall1 : clkSrc1;
	wire logic tick0 = enable0 & src0;
	wire logic tick1 = enable1 & src1;
	wire logic highTick0 = split & run1 & clkSrc0;

	dlct_counter u_counter0 (
		.clk(clk),
		.arst_n(arst_n),
		.modeField(cfg0.modeField),
		.lowTick(tick0),
		.highTick(highTick0),
		.loadLow(loadLow0),
		.loadHigh(loadHigh0),
		.loadData(loadData),
		.count(count0),
		.lowWrap(lowWrap0),
		.fullWrap(fullWrap0),
		.highWrap(highWrap0)
	);

	dlct_counter u_counter1 (
		.clk(clk),
		.arst_n(arst_n),
		.modeField(cfg1.modeField),
		.lowTick(tick1),
		.highTick(1'b0),
		.loadLow(loadLow1),
		.loadHigh(loadHigh1),
		.loadData(loadData),
		.count(count1),
		.lowWrap(lowWrap1),
		.fullWrap(fullWrap1),
		.highWrap()
	);

	// Overflow events; in split mode timer 1 still pulses for other peripherals
	wire logic ovf0 = lowWrap0 | fullWrap0;
	wire logic ovf1Raw = lowWrap1 | fullWrap1;
	wire logic setTf1 = split ? highWrap0 : ovf1Raw;
	wire logic edgeMode0 = timer_run_and_flag_control[`DLCT_BIT_IT0];
	wire logic edgeMode1 = timer_run_and_flag_control[`DLCT_BIT_IT1];
	wire logic setIe0 = edgeMode0 ? irqRise0 : irqActive0;
	wire logic setIe1 = edgeMode1 ? irqRise1 : irqActive1;
	wire logic ctrlHit = (sfrAddr == `DLCT_CTRL_ADDR);
	wire logic byteWr = sfrWrite & ctrlHit;
	wire logic bitWr = sfrBitWrite & ctrlHit & ~sfrWrite;
	wire dlct_acc_t acc = byteWr ? DLCT_ACC_BYTE : (bitWr ? DLCT_ACC_BIT : DLCT_ACC_NONE);

	// Software write first, then vector clears, then hardware sets win over both
	always_comb begin
		next_ctrl = timer_run_and_flag_control;
		case (acc)
			DLCT_ACC_BYTE: next_ctrl = sfrWdata;
			DLCT_ACC_BIT: next_ctrl[sfrBitSel] = sfrWdata[0];
			DLCT_ACC_NONE: next_ctrl = timer_run_and_flag_control;
			default: next_ctrl = timer_run_and_flag_control;
		endcase
		if (vectorAck0)
			next_ctrl[`DLCT_BIT_TF0] = 1'b0;
		if (vectorAck1)
			next_ctrl[`DLCT_BIT_TF1] = 1'b0;
		if (vectorAckExt0 && edgeMode0)
			next_ctrl[`DLCT_BIT_IE0] = 1'b0;
		if (vectorAckExt1 && edgeMode1)
			next_ctrl[`DLCT_BIT_IE1] = 1'b0;
		if (ovf0)
			next_ctrl[`DLCT_BIT_TF0] = 1'b1;
		if (setTf1)
			next_ctrl[`DLCT_BIT_TF1] = 1'b1;
		if (setIe0)
			next_ctrl[`DLCT_BIT_IE0] = 1'b1;
		if (setIe1)
			next_ctrl[`DLCT_BIT_IE1] = 1'b1;
	end

	// Control register; reset to all zeros
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			timer_run_and_flag_control <= `DLCT_CTRL_RESET;
			counter1_overflow_pulse <= 1'b0;
		end else begin
			timer_run_and_flag_control <= next_ctrl;
			counter1_overflow_pulse <= ovf1Raw;
		end
	end

	assign ctrlRdata = timer_run_and_flag_control;
	// Requests held as long as the flag stays set
	assign irqReq0 = timer_run_and_flag_control[`DLCT_BIT_TF0] & irqEnable0;
	assign irqReq1 = timer_run_and_flag_control[`DLCT_BIT_TF1] & irqEnable1;
	assign extIrqReq0 = timer_run_and_flag_control[`DLCT_BIT_IE0];
	assign extIrqReq1 = timer_run_and_flag_control[`DLCT_BIT_IE1];
endmodule // dlct_timers

// ### rtl/dlct_defs.svh
// Constants for the dual legacy counter/timer block.
// Assumes inclusion by bare name; no other dependencies.
`ifndef DLCT_DEFS_SVH
`define DLCT_DEFS_SVH

`define DLCT_CTRL_ADDR 8'h88
`define DLCT_CTRL_RESET 8'h00
`define DLCT_BIT_TF1 3'h7
`define DLCT_BIT_TR1 3'h6
`define DLCT_BIT_TF0 3'h5
`define DLCT_BIT_TR0 3'h4
`define DLCT_BIT_IE1 3'h3
`define DLCT_BIT_IT1 3'h2
`define DLCT_BIT_IE0 3'h1
`define DLCT_BIT_IT0 3'h0
`define DLCT_MODE_13 2'h0
`define DLCT_MODE_16 2'h1
`define DLCT_MODE_RELOAD 2'h2
`define DLCT_MODE_SPLIT 2'h3
`define DLCT_PRE_DIV12 2'h0
`define DLCT_PRE_DIV4 2'h1
`define DLCT_PRE_DIV48 2'h2
`define DLCT_PRE_EXT8 2'h3
`define DLCT_DIV12_LAST 6'h0b
`define DLCT_DIV4_LAST 6'h03
`define DLCT_DIV48_LAST 6'h2f
`define DLCT_EXT8_LAST 6'h07
`define DLCT_LOW5_MASK 8'h1f
`define DLCT_ZERO8 8'h00
`define DLCT_ONE8 8'h01
`define DLCT_ONES8 8'hff

`endif

// ### rtl/dlct_pkg.sv
// Types shared by the counter/timer design.
// Assumes the constants header is on the include path.
package dlct_pkg;
	// Per-timer configuration gathered from mode and clock registers
	typedef struct packed {
		logic gateEnable;
		logic edgeCountSelect;
		logic [1:0] modeField;
		logic sysclkSelect;
	} dlct_cfg_t;

	// Count register pair of one timer
	typedef struct packed {
		logic [7:0] high;
		logic [7:0] low;
	} dlct_count_t;

	typedef enum logic [1:0] {
		DLCT_ACC_NONE,
		DLCT_ACC_BYTE,
		DLCT_ACC_BIT
	} dlct_acc_t;
endpackage

// ### rtl/dlct_counter.sv
// One timer's count register pair with mode logic.
// Assumes tick and enable come from logic on clk; the CPU load wins over a count.
`timescale 1ns/1ps
`include "dlct_defs.svh"
module dlct_counter
	import dlct_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [1:0] modeField,
	input wire logic lowTick,
	input wire logic highTick,
	input wire logic loadLow,
	input wire logic loadHigh,
	input wire logic [7:0] loadData,
	output dlct_count_t count,
	output logic lowWrap,
	output logic fullWrap,
	output logic highWrap
);
	logic [7:0] next_low;
	logic [7:0] next_high;
	wire logic lowAllOnes = (count.low == `DLCT_ONES8);
	wire logic low5AllOnes = ((count.low & `DLCT_LOW5_MASK) == `DLCT_LOW5_MASK);
	wire logic highAllOnes = (count.high == `DLCT_ONES8);
	wire logic is13 = (modeField == `DLCT_MODE_13);
	wire logic is16 = (modeField == `DLCT_MODE_16);
	wire logic isReload = (modeField == `DLCT_MODE_RELOAD);
	wire logic isSplit = (modeField == `DLCT_MODE_SPLIT);
	// Carry out of the low part into the high byte
	wire logic lowCarry = is13 ? low5AllOnes : lowAllOnes;
	assign fullWrap = lowTick & (is13 | is16) & lowCarry & highAllOnes;
	assign lowWrap = lowTick & (isReload | isSplit) & lowAllOnes;
	assign highWrap = highTick & isSplit & highAllOnes;

	// Next-value selection; upper three low bits keep counting freely in 13-bit mode
	always_comb begin
		next_low = count.low;
		next_high = count.high;
		if (lowTick) begin
			if (isReload && lowAllOnes)
				next_low = count.high;
			else
				next_low = count.low + `DLCT_ONE8;
			if ((is13 || is16) && lowCarry)
				next_high = count.high + `DLCT_ONE8;
		end
		if (highTick && isSplit)
			next_high = count.high + `DLCT_ONE8;
		if (loadLow)
			next_low = loadData;
		if (loadHigh)
			next_high = loadData;
	end

	// Count holds when not ticked; run does not clear it
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			count <= '0;
		end else begin
			count <= {next_high, next_low};
		end
	end
endmodule // dlct_counter

// ### tb/dlct_timers_assertions.sv
// Checker for the counter/timer top: control register, gating and flag rules.
// Assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/1ps
module dlct_timers_checker
	import dlct_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [7:0] sfrAddr,
	input wire logic [7:0] sfrWdata,
	input wire logic sfrWrite,
	input wire logic sfrBitWrite,
	input wire logic [2:0] sfrBitSel,
	input wire logic [7:0] ctrlRdata,
	input wire logic loadLow0,
	input wire logic loadHigh0,
	input wire dlct_count_t count0,
	input wire dlct_cfg_t cfg0,
	input wire logic ext_irq0_polarity,
	input wire logic ext_irq0_input,
	input wire logic irqEnable0,
	input wire logic vectorAck0,
	input wire logic irqReq0
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	// Control register decode
	wire logic ctrlHit = sfrAddr == 8'h88;

	a_irq_follows_flag: assert property (irqReq0 == (ctrlRdata[5] && irqEnable0))
		else $error("timer 0 request differs from flag and enable");
	a_byte_write_run: assert property (sfrWrite && ctrlHit |=> ctrlRdata[6] == $past(sfrWdata[6])
		&& ctrlRdata[4] == $past(sfrWdata[4]) && ctrlRdata[0] == $past(sfrWdata[0]))
		else $error("byte write not stored");
	a_bit_write_run: assert property (sfrBitWrite && !sfrWrite && ctrlHit && sfrBitSel == 3'h4
		|=> ctrlRdata[4] == $past(sfrWdata[0])) else $error("bit write not stored");
	a_stray_addr: assert property ((sfrWrite || sfrBitWrite) && !ctrlHit |=> $stable(ctrlRdata[6])
		&& $stable(ctrlRdata[4])) else $error("foreign address changed run bits");
	// Two idle cycles so a pipelined enable cannot hide a stray count
	a_stopped_holds: assert property (!ctrlRdata[4] ##1 (!ctrlRdata[4] && !loadLow0 && !loadHigh0
		&& cfg0.modeField != 2'h3) |=> $stable(count0)) else $error("stopped timer 0 moved");
	a_reload_high_kept: assert property (cfg0.modeField == 2'h2 && !loadHigh0 |=> $stable(count0.high))
		else $error("reload byte changed");
	a_ack_clears_flag: assert property (!ctrlRdata[4] ##1 (vectorAck0 && !ctrlRdata[4] && !sfrWrite
		&& !sfrBitWrite) |=> !ctrlRdata[5]) else $error("vector did not clear timer 0 flag");
	a_level_sets_flag: assert property ((ext_irq0_input == ext_irq0_polarity && !ctrlRdata[0])[*4]
		|=> ctrlRdata[1]) else $error("level input did not set flag");

	c_tf0: cover property ($rose(ctrlRdata[5]));
	c_tf1: cover property ($rose(ctrlRdata[7]));
	c_ext0: cover property ($rose(ctrlRdata[1]));
endmodule // dlct_timers_checker

bind dlct_timers dlct_timers_checker dlct_timers_checker_inst (.clk, .arst_n, .sfrAddr, .sfrWdata, .sfrWrite,
	.sfrBitWrite, .sfrBitSel, .ctrlRdata, .loadLow0, .loadHigh0, .count0, .cfg0, .ext_irq0_polarity,
	.ext_irq0_input, .irqEnable0, .vectorAck0, .irqReq0);

// ### tb/dlct_cpu_model.sv
// CPU-side model of the register port.
// Assumes its task is entered just after a falling clock edge.
`timescale 1ns/1ps
module dlct_cpu_model (
	input wire logic clk,
	output logic [7:0] sfrAddr,
	output logic [7:0] sfrWdata,
	output logic sfrWrite,
	output logic sfrBitWrite,
	output logic [2:0] sfrBitSel
);
	initial begin
		sfrAddr = 8'h00;
		sfrWdata = 8'h00;
		sfrWrite = 1'b0;
		sfrBitWrite = 1'b0;
		sfrBitSel = 3'h0;
	end
	// One-cycle strobe; released lines are inverted so stale values never pass
	// Trailing idle cycle keeps back-to-back calls from re-driving a strobe in one step
	task automatic access(logic [7:0] a, logic [7:0] d, logic b, logic [2:0] s);
		sfrAddr = a;
		sfrWdata = d;
		sfrBitSel = s;
		sfrWrite = !b;
		sfrBitWrite = b;
		@(negedge clk);
		sfrWrite = 1'b0;
		sfrBitWrite = 1'b0;
		sfrAddr = ~a;
		sfrWdata = ~d;
		@(negedge clk);
	endtask
endmodule // dlct_cpu_model

// ### tb/tb.sv
// Bench for the dual counter/timer: table of timer runs against an integer model.
// Assumes the CPU model drives the register port and the checker is bound.
`timescale 1ns/1ps
module tb;
	import dlct_pkg::*;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [7:0] sfrAddr, sfrWdata, ctrlRdata;
	logic sfrWrite, sfrBitWrite, counter1_overflow_pulse;
	logic [2:0] sfrBitSel;
	logic [7:0] loadData = 8'h00;
	logic [3:0] ld = 4'h0; // Low0, high0, low1, high1
	dlct_count_t count0, count1;
	dlct_cfg_t cfg[2] = '{5'h00, 5'h00};
	logic [1:0] shared_prescale_code = 2'h0;
	logic [1:0] pol = 2'h3, irqIn = 2'h0, pin = 2'h3, ien = 2'h3, ack = 2'h0, ackExt = 2'h0, irqReq, extReq;
	logic extClockPin = 1'b0;
	int miscompares = 0;
	int checked = 0;
	logic [31:0] seed = 32'h4655;

	always #20 clk = ~clk;
	// Free-running external prescaler clock, one rise every two cycles
	always @(negedge clk) extClockPin <= ~extClockPin;

	dlct_cpu_model dlct_cpu_model_inst (.clk, .sfrAddr, .sfrWdata, .sfrWrite, .sfrBitWrite, .sfrBitSel);
	dlct_timers dlct_timers_inst (.clk, .arst_n, .sfrAddr, .sfrWdata, .sfrWrite, .sfrBitWrite, .sfrBitSel, .ctrlRdata,
		.loadLow0(ld[0]), .loadHigh0(ld[1]), .loadLow1(ld[2]), .loadHigh1(ld[3]), .loadData, .count0, .count1,
		.cfg0(cfg[0]), .cfg1(cfg[1]), .shared_prescale_code, .ext_irq0_polarity(pol[0]), .ext_irq1_polarity(pol[1]),
		.ext_irq0_input(irqIn[0]), .ext_irq1_input(irqIn[1]), .counter0_edge_pin(pin[0]), .counter1_edge_pin(pin[1]),
		.extClockPin, .irqEnable0(ien[0]), .irqEnable1(ien[1]), .vectorAck0(ack[0]), .vectorAck1(ack[1]),
		.vectorAckExt0(ackExt[0]), .vectorAckExt1(ackExt[1]), .irqReq0(irqReq[0]), .irqReq1(irqReq[1]),
		.extIrqReq0(extReq[0]), .extIrqReq1(extReq[1]), .counter1_overflow_pulse);

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// One count step of the model; bit 16 marks a wrap
	function automatic logic [16:0] step(logic [1:0] m, logic [15:0] v);
		int c;
		c = (m == 2'h0) ? {v[15:8], v[4:0]} + 1 : v + 1;
		if (m == 2'h0)
			return {c[13], c[12:5], v[7:5], c[4:0]};
		if (m == 2'h2)
			return {v[7:0] == 8'hff, v[15:8], v[7:0] == 8'hff ? v[15:8] : c[7:0]};
		return c[16:0];
	endfunction

	task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(logic [7:0] a, logic [7:0] d, logic b = 1'b0, logic [2:0] s = 3'h0);
		dlct_cpu_model_inst.access(a, d, b, s);
	endtask

	task automatic pulse(logic [1:0] a, logic [1:0] e);
		ack = a;
		ackExt = e;
		@(negedge clk);
		ack = 2'h0;
		ackExt = 2'h0;
	endtask

	// Low byte then high byte, one strobe each
	task automatic load(int t, logic [15:0] v);
		loadData = v[7:0];
		ld[2 * t] = 1'b1;
		@(negedge clk);
		ld[2 * t] = 1'b0;
		loadData = v[15:8];
		ld[2 * t + 1] = 1'b1;
		@(negedge clk);
		ld[2 * t + 1] = 1'b0;
	endtask

	// 96-cycle run window so every prescaler period divides it evenly
	task automatic run(int t, logic [4:0] c, logic [1:0] sc, logic gateOn);
		logic [15:0] v, m;
		logic [16:0] r;
		logic flag;
		int inc;
		cfg[t] = c;
		shared_prescale_code = sc;
		irqIn[t] = gateOn;
		wr(8'h88, 8'h00);
		v = 16'hffff - 16'(rnd() % 40);
		load(t, v);
		wr(8'h88, 8'h10 << (2 * t));
		inc = 0;
		for (int i = 1; i < 95; i++) begin
			if (i % 6 == 1 && i < 80) pin[t] = 1'b0;
			if (i % 6 == 4) pin[t] = 1'b1;
			inc += int'(c[3] && i % 6 == 1 && i < 80);
			@(negedge clk);
		end
		irqIn[t] = 1'b0;
		wr(8'h88, 8'h00, 1'b1, 3'(4 + 2 * t));
		if (c[4] && !gateOn) inc = 0;
		else if (!c[3]) inc = c[0] ? 96 : 96 / (sc == 2'h0 ? 12 : sc == 2'h1 ? 4 : sc == 2'h2 ? 48 : 8 * 2);
		flag = 1'b0;
		repeat (inc) begin
			r = step(c[2:1], v);
			v = r[15:0];
			flag |= r[16];
		end
		m = (c[2:1] == 2'h0) ? 16'hff1f : 16'hffff;
		@(negedge clk);
		chk("count", v & m, (t ? count1 : count0) & m);
		chk("flag", flag, ctrlRdata[5 + 2 * t]);
		chk("irq", flag, irqReq[t]);
		pulse(2'h1 << t, 2'h0);
		chk("ack", 16'h0000, ctrlRdata[5 + 2 * t]);
		$display("test timer %0d cfg %h done", t, c);
	endtask

	task final_report;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (3) @(negedge clk);
		arst_n = 1'b1;
		chk("reset", 16'h0000, ctrlRdata);
		wr(8'h88, 8'haa);
		wr(8'h89, 8'h00);
		chk("ctrl", 16'h00aa, ctrlRdata);
		chk("irqs", 16'h0003, irqReq);
		wr(8'h88, 8'h00);
		run(0, 5'h03, 2'h0, 1'b0);
		run(0, 5'h01, 2'h0, 1'b0);
		run(0, 5'h05, 2'h0, 1'b0);
		run(1, 5'h03, 2'h0, 1'b0);
		run(1, 5'h0c, 2'h0, 1'b0);
		run(0, 5'h0a, 2'h0, 1'b0);
		for (int s = 0; s < 4; s++) run(0, 5'h02, 2'(s), 1'b0);
		run(0, 5'h13, 2'h0, 1'b0);
		run(1, 5'h13, 2'h0, 1'b1);
		chk("ext1 level", 16'h0001, extReq[1]);
		// Split: low byte on run 0, high byte on run 1; timer 1 only pulses
		wr(8'h88, 8'h00);
		load(1, 16'hffff);
		load(0, 16'hf0f0);
		cfg[0] = 5'h07;
		cfg[1] = 5'h05;
		repeat (2) @(negedge clk);
		chk("split tf1", 16'h0000, ctrlRdata[7]);
		chk("split pulse", 16'h0001, counter1_overflow_pulse);
		wr(8'h88, 8'h50);
		repeat (16) @(negedge clk);
		wr(8'h88, 8'h00, 1'b1, 3'h4);
		wr(8'h88, 8'h00, 1'b1, 3'h6);
		chk("split low", 16'h0002, count0.low);
		chk("split high", 16'h0004, count0.high);
		chk("split flags", 16'h00a0, ctrlRdata);
		cfg[1] = 5'h07;
		repeat (2) @(negedge clk);
		chk("split stop", 16'h0000, counter1_overflow_pulse);
		cfg[0] = 5'h00;
		$display("test split mode done");
		irqIn[0] = 1'b1;
		repeat (6) @(negedge clk);
		chk("level", 16'h0001, extReq[0]);
		irqIn[0] = 1'b0;
		repeat (3) @(negedge clk);
		wr(8'h88, 8'h00, 1'b1, 3'h1);
		chk("swclr", 16'h0000, extReq[0]);
		wr(8'h88, 8'h01, 1'b1, 3'h0);
		irqIn[0] = 1'b1;
		repeat (6) @(negedge clk);
		chk("edge", 16'h0001, extReq[0]);
		pulse(2'h0, 2'h1);
		chk("extack", 16'h0000, extReq[0]);
		$display("test external interrupt done");
		final_report();
	end

	// Span well above the roughly 1300 cycles the tests take
	initial begin
		repeat (5000) @(posedge clk);
		miscompares++;
		final_report();
	end
endmodule // tb
